// ### hw/bul_top.sv
`timescale 1ns/1ps
`include "bul_defs.svh"
// Contract
// - fuse done flag only after load ends
// - fuse load starts itself after reset
// - accumulate mode ORs all sync positions
// - otherwise positions of last edge only
// - strobe request until strobe seen
// - sync request, sync seen, then release
// - oscillator off: settings apply without hold
// - align before oscillator on if wanted
// - check repeating eight-sample link pattern
// - stop on fail, or continue reporting
// - only used banks, minus masked banks
// - alarm bits write one to clear
module bul_top import bul_pkg::*; #(
    parameter int LANES        = 12,    // link data lanes
    parameter int BANKS        = 4,     // lane banks
    parameter int FUSE_CYCLES  = 64,    // fuse copy length
    parameter int LINK_TIMEOUT = 32,    // idle link clock limit
    parameter int FREQ_W       = 16     // oscillator word width
) (
    input  wire logic              pclk,          // device clock
    input  wire logic              presetn,       // async reset, low
    input  wire logic              psel,          // apb select
    input  wire logic              penable,       // apb enable
    input  wire logic              pwrite,        // apb direction
    input  wire logic [15:0]       paddr,         // apb byte address
    input  wire logic [31:0]       pwdata,        // apb write data
    output logic      [31:0]       prdata,        // apb read data
    output logic                   pready,        // apb ready
    output logic                   pslverr,       // unmapped access
    input  wire logic              link_clk,      // link clock pin
    input  wire logic [LANES-1:0]  link_data,     // link data pins
    input  wire logic              link_strobe,   // dedicated strobe
    input  wire logic              sync_pulse,    // sync pulse pin
    input  wire logic              link_hold_low_input_n, // sync hold
    input  wire logic              tx_gate_pin,   // transmit gate pin
    output logic                   datapath_on,   // datapath enable
    output logic                   tx_active,     // transmit enabled
    output logic [FREQ_W-1:0]      osc_freq,      // active frequency
    output logic                   check_running  // check in progress
);
    localparam int BW = LANES / BANKS;          // lanes per bank
    localparam int CW = $clog2(FUSE_CYCLES + 1);
    localparam int IW = $clog2(LINK_TIMEOUT + 1);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [LANES-1:0] data_s;                   // lanes
    logic lclk_s, strb_s, sync_s, holdn_s, txp_s; // control pins
    bul_sync #(.W(LANES + 5)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({link_clk, link_strobe, sync_pulse,
                   link_hold_low_input_n, tx_gate_pin, link_data}),
        .q       ({lclk_s, strb_s, sync_s, holdn_s, txp_s, data_s})
    );

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [12:0]       ctrl;                    // control bits
    logic [10:0]       cfg;                     // mode, mask, delay
    logic [7:0]        spos_ctl;                // sync position control
    logic [2:0]        alarm;                   // sticky alarms
    logic [LANES-1:0]  pat [8];                 // check pattern
    logic [FREQ_W-1:0] freq_shadow;             // last written word
    logic              fuse_done;               // load complete
    logic [CW-1:0]     fuse_cnt;                // load progress
    logic              strobe_seen, sync_seen;  // alignment status
    logic [7:0]        sync_pos;                // sync edge positions
    logic [LANES-1:0]  chk_miss, fail_data;     // lane misses, frame
    logic [2:0]        fail_idx, idx, smp_cnt;  // pattern positions
    logic              chk_sum;                 // any failure
    bul_chk_type       chk_st;                  // check state
    logic              lclk_q, stb_prev, sync_q; // edge history
    logic [IW-1:0]     idle;                    // cycles since edge
    logic              stb_seen_q, syn_seen_q;  // seen flags, one cycle late
    logic              chk_lock;                // first compare made since launch

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire [11:0] ridx    = paddr[13:2];
    wire        acc     = psel && penable;
    wire        wr      = acc && pwrite;
    wire        hit_pat = (ridx[11:3] == `BUL_IDX_PATB);
    wire        hit     = hit_pat || ridx == `BUL_IDX_FUSE
                       || ridx == `BUL_IDX_SPOS || ridx == `BUL_IDX_CTRL
                       || ridx == `BUL_IDX_CFG  || ridx == `BUL_IDX_STAT
                       || ridx == `BUL_IDX_ALRM || ridx == `BUL_IDX_FREQ
                       || ridx == `BUL_IDX_FACT || ridx == `BUL_IDX_FAIL;
    wire        ctrl_wr = wr && ridx == `BUL_IDX_CTRL;
    wire        spos_wr = wr && ridx == `BUL_IDX_SPOS;
    wire        alm_wr  = wr && ridx == `BUL_IDX_ALRM;
    wire        freq_wr = wr && ridx == `BUL_IDX_FREQ;
    wire        trig    = ctrl_wr && pwdata[`BUL_C_TRIG];
    wire        osc_on  = ctrl[`BUL_C_OSC];
    wire        hold    = ctrl[`BUL_C_HOLD];
    wire        acc_on  = spos_ctl[0];
    // answer in the first access cycle; read data caught in setup
    assign pready  = acc;
    assign pslverr = acc && !hit;
    assign datapath_on   = ctrl[`BUL_C_DP];
    assign tx_active     = txp_s || (|ctrl[`BUL_C_TXHI:`BUL_C_TXLO]);
    assign check_running = (chk_st == BUL_RUN);

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    logic [31:0] rd;
    always_comb
    begin
        rd = 32'h0;
        if (hit_pat)
            rd[LANES-1:0] = pat[ridx[2:0]];
        else if (ridx == `BUL_IDX_FUSE)
            rd[7:0] = {`BUL_FUSE_RSVD, fuse_done};
        else if (ridx == `BUL_IDX_SPOS)
            rd[7:0] = spos_ctl;
        else if (ridx == `BUL_IDX_CTRL)
            rd[12:0] = ctrl;
        else if (ridx == `BUL_IDX_CFG)
            rd[10:0] = cfg;
        else if (ridx == `BUL_IDX_STAT)
            rd = {{(16 - LANES){1'b0}}, chk_miss, sync_pos, 4'h0,
                  chk_sum, check_running, sync_seen, strobe_seen};
        else if (ridx == `BUL_IDX_ALRM)
            rd[2:0] = alarm;
        else if (ridx == `BUL_IDX_FREQ)
            rd[FREQ_W-1:0] = freq_shadow;
        else if (ridx == `BUL_IDX_FACT)
            rd[FREQ_W-1:0] = osc_freq;
        else if (ridx == `BUL_IDX_FAIL)
            rd = {13'h0, fail_idx, {(16 - LANES){1'b0}}, fail_data};
    end

    // ----------------------------------------------------------------
    // link edges and timing
    // ----------------------------------------------------------------
    wire       link_edge = lclk_s && !lclk_q;
    wire       stb_now   = ctrl[`BUL_C_LSB] ? data_s[0] : strb_s;
    wire       stb_edge  = link_edge && stb_now && !stb_prev;
    wire       hold_n    = holdn_s && ctrl[`BUL_C_SYNN];
    wire       sync_hit  = sync_s && !sync_q && hold_n;
    wire [2:0] phase     = (idle > IW'(7)) ? 3'h7 : 3'(idle);
    wire [7:0] pos_hot   = 8'h01 << phase;
    wire       str_arm   = datapath_on && ctrl[`BUL_C_STRQ];
    wire       syn_arm   = datapath_on && ctrl[`BUL_C_SYRQ];

    // edge history and idle count; idle stops at the alarm limit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lclk_q   <= 1'b0;
            sync_q   <= 1'b0;
            stb_prev <= 1'b0;
            idle     <= '0;
            smp_cnt  <= 3'h0;
        end
        else
        begin
            lclk_q <= lclk_s;
            sync_q <= sync_s;
            if (link_edge)
                stb_prev <= stb_now;
            if (link_edge)
                idle <= '0;
            else if (idle != IW'(LINK_TIMEOUT))
                idle <= idle + IW'(1);
            if (stb_edge)
                smp_cnt <= 3'h1;
            else if (link_edge)
                smp_cnt <= smp_cnt + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // fuse loader
    // ----------------------------------------------------------------
    // load runs by itself from reset release
    // flag rises only when the copy finishes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fuse_cnt  <= '0;
            fuse_done <= 1'b0;
        end
        else if (!fuse_done)
        begin
            fuse_cnt  <= fuse_cnt + CW'(1);
            fuse_done <= (fuse_cnt == CW'(FUSE_CYCLES - 1));
        end
    end

    // ----------------------------------------------------------------
    // control and configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl        <= `BUL_CTRL_RST;
            cfg         <= '0;
            spos_ctl    <= 8'h00;
            freq_shadow <= '0;
            osc_freq    <= '0;
        end
        else
        begin
            // trigger bit is a pulse and never stored
            if (ctrl_wr)
                ctrl <= pwdata[12:0] & ~(13'h1 << `BUL_C_TRIG);
            if (wr && ridx == `BUL_IDX_CFG)
                cfg <= pwdata[10:0];
            if (spos_wr)
                spos_ctl <= pwdata[7:0];
            if (freq_wr)
                freq_shadow <= pwdata[FREQ_W-1:0];
            // oscillator off, words apply at once
            // hold clear, word applies at once, no alignment is awaited
            if (freq_wr && (!osc_on || !hold))
                osc_freq <= pwdata[FREQ_W-1:0];
            else if (ctrl_wr && hold && !pwdata[`BUL_C_HOLD])
                osc_freq <= freq_shadow;
        end
    end

    // pattern store, one word per sample
    always_ff @(posedge pclk)
    begin
        if (wr && hit_pat)
            pat[ridx[2:0]] <= pwdata[LANES-1:0];
    end

    // ----------------------------------------------------------------
    // alignment, positions and alarms
    // ----------------------------------------------------------------
    // link alarm is a level: a link that never ran must still raise it
    wire [2:0] alm_set = {(strobe_seen && !stb_seen_q) || (sync_seen && !syn_seen_q),
                          strobe_seen && stb_edge && smp_cnt != 3'h0,
                          datapath_on && idle >= IW'(LINK_TIMEOUT - 1)};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strobe_seen <= 1'b0;
            sync_seen   <= 1'b0;
            sync_pos    <= 8'h00;
            alarm       <= 3'h0;
            prdata      <= 32'h0;
            stb_seen_q  <= 1'b0;
            syn_seen_q  <= 1'b0;
        end
        else
        begin
            stb_seen_q <= strobe_seen;
            syn_seen_q <= sync_seen;
            if (psel && !penable)
                prdata <= rd;
            if (ctrl_wr && !pwdata[`BUL_C_STRQ])
                strobe_seen <= 1'b0;
            else if (str_arm && stb_edge)
                strobe_seen <= 1'b1;
            // sync seen holds until request drops
            if (ctrl_wr && !pwdata[`BUL_C_SYRQ])
                sync_seen <= 1'b0;
            else if (syn_arm && sync_hit)
                sync_seen <= 1'b1;
            // accumulate since the bit was set
            // last edge only while bit is clear
            if (spos_wr && pwdata[0] && !acc_on)
                sync_pos <= 8'h00;
            else if (sync_hit)
                sync_pos <= acc_on ? (sync_pos | pos_hot) : pos_hot;
            // ones clear, zeros keep; set wins
            alarm <= (alarm & ~(alm_wr ? pwdata[2:0] : 3'h0)) | alm_set;
        end
    end

    // ----------------------------------------------------------------
    // link check lanes
    // ----------------------------------------------------------------
    // used banks follow channel mode, mask removes
    logic [LANES-1:0] lane_on;
    genvar gl;
    generate
        for (gl = 0; gl < LANES; gl++)
        begin : g_lane
            assign lane_on[gl] = ((cfg[1:0] != 2'b00) || (gl / BW) < BANKS / 2)
                && !cfg[3 + gl / BW] && !(ctrl[`BUL_C_LSB] && gl == 0);
        end
    endgenerate

    // compare each sample with its pattern slot
    wire [2:0]       cur_idx = (ctrl[`BUL_C_SHLD] && stb_now) ? 3'h0 : idx;
    wire [LANES-1:0] diff    = (data_s ^ pat[cur_idx]) & lane_on;
    // with strobe hold, comparing waits for the first strobe sample
    wire             cmp     = link_edge && check_running
                               && (chk_lock || !ctrl[`BUL_C_SHLD] || stb_now);
    wire             fail    = cmp && (|diff);

    // check state and results
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            chk_st    <= BUL_IDLE;
            idx       <= 3'h0;
            chk_miss  <= '0;
            chk_sum   <= 1'b0;
            fail_idx  <= 3'h0;
            fail_data <= '0;
            chk_lock  <= 1'b0;
        end
        else if (!ctrl[`BUL_C_CEN])
            chk_st <= BUL_IDLE;
        else if (trig && tx_active)
        begin
            chk_st   <= BUL_RUN;
            idx      <= 3'h0;
            chk_miss <= '0;
            chk_sum  <= 1'b0;
            chk_lock <= 1'b0;
        end
        else if (cmp)
        begin
            chk_lock <= 1'b1;
            idx      <= cur_idx + 3'h1;
            chk_miss <= chk_miss | diff;
            chk_sum  <= chk_sum | fail;
            // stop and keep the frame unless continuing
            if (fail && !ctrl[`BUL_C_CONT])
            begin
                chk_st    <= BUL_STOP;
                fail_idx  <= cur_idx;
                fail_data <= data_s;
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [CW:0] since_rst;                      // cycles from release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_rst <= '0;
        else if (!since_rst[CW])
            since_rst <= since_rst + (CW+1)'(1);
    end
    sequence s_sync_arm;
        syn_arm && sync_hit && !ctrl_wr;
    endsequence
    sequence s_fail_stop;
        fail && !ctrl[`BUL_C_CONT] && ctrl[`BUL_C_CEN] && !trig;
    endsequence
    a_fuse_done_late: assert property ($rose(fuse_done) |->
        $past(fuse_cnt) == CW'(FUSE_CYCLES - 1)) else $error("fuse done early");
    a_fuse_self_start: assert property (
        since_rst == (CW+1)'(FUSE_CYCLES) |-> fuse_done) else $error("no fuse load");
    a_pos_accum_keep: assert property (acc_on && $past(acc_on) |->
        (sync_pos & $past(sync_pos)) == $past(sync_pos)) else $error("position lost");
    a_pos_last_only: assert property (!acc_on && sync_hit && !spos_wr
        |=> sync_pos == $past(pos_hot)) else $error("stale position");
    a_strobe_seen_cause: assert property ($rose(strobe_seen) |->
        $past(str_arm && stb_edge)) else $error("strobe seen unarmed");
    a_sync_seen_set: assert property (s_sync_arm |=>
        sync_seen) else $error("sync not seen");
    a_osc_free_write: assert property (freq_wr && !osc_on |=>
        osc_freq == $past(pwdata[FREQ_W-1:0])) else $error("word not applied");
    a_check_fail_stop: assert property (s_fail_stop |=>
        chk_st == BUL_STOP && chk_sum ##1 !check_running) else $error("no stop");
    a_bank_no_miss: assert property (
        ((chk_miss & ~$past(chk_miss)) & ~$past(lane_on)) == '0)
        else $error("masked lane miss");
    a_alarm_zero_keep: assert property (alm_wr |=>
        (alarm & $past(alarm & ~pwdata[2:0])) == $past(alarm & ~pwdata[2:0]))
        else $error("alarm lost");
endmodule

// ### hw/bul_defs.svh
`ifndef BUL_DEFS_SVH
`define BUL_DEFS_SVH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define BUL_IDX_FUSE   12'h900
`define BUL_IDX_SPOS   12'hb02
`define BUL_IDX_CTRL   12'hc00
`define BUL_IDX_CFG    12'hc01
`define BUL_IDX_STAT   12'hc02
`define BUL_IDX_ALRM   12'hc03
`define BUL_IDX_PATB   9'h181
`define BUL_IDX_FREQ   12'hc10
`define BUL_IDX_FACT   12'hc11
`define BUL_IDX_FAIL   12'hc12
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BUL_FUSE_RSVD  7'h01
`define BUL_C_DP       0
`define BUL_C_STRQ     1
`define BUL_C_SYRQ     2
`define BUL_C_OSC      3
`define BUL_C_HOLD     4
`define BUL_C_TXLO     5
`define BUL_C_TXHI     6
`define BUL_C_CEN      7
`define BUL_C_CONT     8
`define BUL_C_SHLD     9
`define BUL_C_TRIG     10
`define BUL_C_SYNN     11
`define BUL_C_LSB      12
`define BUL_CTRL_RST   13'h0800
`define BUL_ALM_LCLK   0
`define BUL_ALM_STRB   1
`define BUL_ALM_REAL   2
`define BUL_STAT_POS   8
`define BUL_STAT_MISS  16
`define BUL_FAIL_IDX   16
`endif

// ### hw/bul_pkg.sv
package bul_pkg;
    // link check sequencing
    typedef enum logic [1:0] {
        BUL_IDLE,
        BUL_RUN,
        BUL_STOP
    } bul_chk_type;
endpackage

// ### hw/bul_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pins from outside the pclk domain
module bul_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,     // device clock
    input  wire logic         presetn,  // async reset, active low
    input  wire logic [W-1:0] d,        // asynchronous pins
    output logic      [W-1:0] q         // synchronised copy
);
    logic [W-1:0] meta;                 // first stage, read only by q

    // ----------------------------------------------------------------
    // two stages
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ### tb/bul_link_src.sv
`timescale 1ns/1ps
// link source: streams the eight-sample loop on its own 320 ns clock
module bul_link_src (
    input  wire logic        run,         // stream on
    input  wire logic [11:0] flip,        // lanes to corrupt
    input  wire logic [2:0]  flip_at,     // sample to corrupt
    output logic             link_clk,    // still while idle
    output logic [11:0]      link_data,   // data lanes
    output logic             link_strobe  // high on sample 0
);
    logic [2:0] idx;  // place in the loop
    initial
    begin
        link_clk = 1'b0;
        link_data = 12'h000;
        link_strobe = 1'b0;
        idx = 3'h0;
    end
    always
    begin
        #160;
        if (!run)
        begin
            // idle: clock stands, data toggles so no stale value looks valid
            link_clk = 1'b0;
            link_strobe = 1'b0;
            link_data = ~link_data;
        end
        else if (link_clk)
        begin
            // launch on the falling edge, half a period of setup
            link_clk = 1'b0;
            idx = idx + 3'h1;
            link_strobe = (idx == 3'h0);
            link_data = (12'h111 * (idx + 1)) ^ ((idx == flip_at) ? flip : 12'h000);
        end
        else
            link_clk = 1'b1;
    end
endmodule

// ### tb/bringup_and_link_check_tb.sv
`timescale 1ns/1ps
`include "bul_defs.svh"
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
$display("[ERR] %s exp %0h got %0h", n, e, a); end end
module bringup_and_link_check_tb;
    logic        pclk = 1'b0, presetn = 1'b0;                 // clock, reset
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;  // apb request
    logic [15:0] paddr = 16'h0000;                            // byte address
    logic [31:0] pwdata = 32'h0, prdata, rdv;                 // data, last read
    logic        pready, pslverr, errv;                       // apb answer
    logic        link_clk, link_strobe, run = 1'b0;           // link source
    logic [11:0] link_data, flip = 12'h000;                   // lanes, faults
    logic [2:0]  fat = 3'h0;                                  // faulty sample
    logic        sync_pulse = 1'b0, tx_gate_pin = 1'b0;       // pins
    logic        datapath_on, tx_active, check_running;      // status
    logic [15:0] osc_freq;                                    // oscillator
    logic [7:0]  p1, p2;                                      // sync positions
    int          fail_count = 0, n_checks = 0;                // counters

    always #20 pclk = ~pclk;

    // short fuse copy keeps the run brief
    bul_top #(.FUSE_CYCLES(8)) u_bul_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .link_data(link_data),
        .link_strobe(link_strobe), .sync_pulse(sync_pulse), .link_hold_low_input_n(1'b1),
        .tx_gate_pin(tx_gate_pin), .datapath_on(datapath_on), .tx_active(tx_active),
        .osc_freq(osc_freq), .check_running(check_running));
    bul_link_src u_bul_link_src (.run(run), .flip(flip), .flip_at(fat), .link_clk(link_clk),
        .link_data(link_data), .link_strobe(link_strobe));

    // one apb transfer; idle edge after so the next setup never collides
    task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        `CHK("pready", 1'b1, pready)
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] i, input logic [31:0] d); apb(1'b1, i, d); endtask
    task automatic rd(input logic [11:0] i); apb(1'b0, i, 32'h0); endtask
    task automatic poll(input logic [11:0] i, input int b, input logic v);
        int n;
        n = 0;
        do begin rd(i); n++; end while (rdv[b] !== v && n < 100);
    endtask
    // sync edge k device clocks after a link clock rise
    task automatic sedge(input int k);
        @(posedge link_clk);
        repeat (k) @(posedge pclk);
        sync_pulse <= 1'b1;
        repeat (12) @(posedge pclk);
        sync_pulse <= 1'b0;
        repeat (12) @(posedge pclk);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic t_fuse;
        rd(`BUL_IDX_FUSE);
        `CHK("fuse busy", 32'h2, rdv)
        poll(`BUL_IDX_FUSE, 0, 1'b1);
        `CHK("fuse done", 32'h3, rdv)
        rd(`BUL_IDX_SPOS);
        `CHK("spos reset", 32'h0, rdv)
        rd(12'h123);
        `CHK("unmapped err", 1'b1, errv)
        `CHK("unmapped data", 32'h0, rdv)
        $display("test fuse done");
    endtask
    task automatic t_alarm;
        run <= 1'b0;
        wr(`BUL_IDX_CTRL, 32'h801);
        repeat (40) @(posedge pclk);
        rd(`BUL_IDX_ALRM);
        `CHK("alarm set", 1'b1, rdv[0])
        wr(`BUL_IDX_ALRM, 32'h0);
        rd(`BUL_IDX_ALRM);
        `CHK("alarm kept", 1'b1, rdv[0])
        run <= 1'b1;
        repeat (20) @(posedge pclk);
        wr(`BUL_IDX_ALRM, 32'h7);
        rd(`BUL_IDX_ALRM);
        `CHK("alarm cleared", 1'b0, rdv[0])
        $display("test alarm done");
    endtask
    task automatic t_strobe;
        wr(`BUL_IDX_CTRL, 32'h803);
        poll(`BUL_IDX_STAT, 0, 1'b1);
        `CHK("strobe seen", 1'b1, rdv[0])
        wr(`BUL_IDX_CTRL, 32'h801);
        rd(`BUL_IDX_STAT);
        `CHK("strobe seen off", 1'b0, rdv[0])
        $display("test strobe done");
    endtask
    task automatic t_sync;
        wr(`BUL_IDX_SPOS, 32'h0);
        wr(`BUL_IDX_CTRL, 32'h805);
        sedge(1);
        rd(`BUL_IDX_STAT);
        p1 = rdv[15:8];
        `CHK("sync seen", 1'b1, rdv[1])
        `CHK("one pos", 1, $countones(p1))
        sedge(5);
        rd(`BUL_IDX_STAT);
        p2 = rdv[15:8];
        `CHK("last only", 1, $countones(p2))
        `CHK("pos moved", 1'b1, p1 !== p2)
        wr(`BUL_IDX_SPOS, 32'h1);
        sedge(1);
        sedge(5);
        rd(`BUL_IDX_STAT);
        `CHK("accumulated", p1 | p2, rdv[15:8])
        wr(`BUL_IDX_CTRL, 32'h801);
        rd(`BUL_IDX_STAT);
        `CHK("sync seen off", 1'b0, rdv[1])
        $display("test sync done");
    endtask
    task automatic t_stop;
        int n;
        for (int i = 0; i < 8; i++) wr({`BUL_IDX_PATB, i[2:0]}, 32'(32'h111 * (i + 1)));
        wr(`BUL_IDX_CFG, 32'h81);
        flip <= 12'h020;
        fat <= 3'h3;
        wr(`BUL_IDX_ALRM, 32'h7);
        repeat (100) @(posedge pclk);
        wr(`BUL_IDX_CTRL, 32'ha81);
        wr(`BUL_IDX_CTRL, 32'haa1);
        `CHK("tx on", 1'b1, tx_active)
        wr(`BUL_IDX_CTRL, 32'hea1);
        n = 0;
        while (check_running === 1'b1 && n < 3000) begin @(posedge pclk); n++; end
        `CHK("stopped", 1'b0, check_running)
        rd(`BUL_IDX_STAT);
        `CHK("summary", 1'b1, rdv[3])
        `CHK("misses", 12'h020, rdv[27:16])
        rd(`BUL_IDX_FAIL);
        `CHK("fail index", 3'h3, rdv[18:16])
        `CHK("fail data", 12'h464, rdv[11:0])
        $display("test stop done");
    endtask
    task automatic t_cont;
        wr(`BUL_IDX_CTRL, 32'h801);
        wr(`BUL_IDX_CFG, 32'h10);
        flip <= 12'h212;
        fat <= 3'h5;
        wr(`BUL_IDX_CTRL, 32'hba1);
        wr(`BUL_IDX_CTRL, 32'hfa1);
        repeat (200) @(posedge pclk);
        `CHK("running", 1'b1, check_running)
        rd(`BUL_IDX_STAT);
        `CHK("used lanes", 12'h002, rdv[27:16])
        `CHK("summary", 1'b1, rdv[3])
        $display("test cont done");
    endtask
    task automatic t_osc;
        wr(`BUL_IDX_CTRL, 32'h801);
        wr(`BUL_IDX_FREQ, 32'h1234);
        `CHK("osc off", 16'h1234, osc_freq)
        wr(`BUL_IDX_CTRL, 32'h819);
        wr(`BUL_IDX_FREQ, 32'h5678);
        `CHK("osc held", 16'h1234, osc_freq)
        wr(`BUL_IDX_CTRL, 32'h809);
        `CHK("osc applied", 16'h5678, osc_freq)
        $display("test osc done");
    endtask

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_fuse;
        t_alarm;
        t_strobe;
        t_sync;
        t_stop;
        t_cont;
        t_osc;
        conclude;
    end
    initial
    begin
        #2_000_000;
        fail_count++;
        conclude;
    end
endmodule
